// >>> verilog/npic_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// controller for vectors 0..13; vector n sits at FFFA - 2n
module npic_ctrl #(
  parameter int NV = 14
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // cpu core handshake
  input wire logic insn_boundary,
  input wire logic trap_req,
  input wire logic return_from_handler,
  input wire logic [7:0] popped_cc,
  input wire logic cc_write,
  input wire logic [7:0] cc_wdata,
  input wire logic wait_enter,
  input wire logic halt_enter,
  output logic service_take,
  output logic stack_context,
  output logic [15:0] vector_addr,
  output logic [3:0] vector_num,
  output logic vector_nmi,
  output logic [7:0] condition_code_reg,
  output logic level_bit_high,
  output logic level_bit_low,
  output logic cpu_run,
  // priority register port
  input wire logic prio_we,
  input wire logic [1:0] prio_addr,
  input wire logic [7:0] prio_wdata,
  output logic [7:0] prio_rdata,
  // external pins, per-vector groups of four
  input wire logic [4*NV-1:0] ext_pins,
  input wire logic [NV-1:0] ext_pin_sel,
  input wire logic [NV-1:0] ext_edge_mode,
  // peripheral sources
  input wire logic [NV-1:0] periph_flag,
  input wire logic [NV-1:0] periph_enable,
  input wire logic [NV-1:0] src_clear,
  input wire logic [NV-1:0] halt_capable,
  output logic [NV-1:0] pending
);
  generate
    if (NV > npic_pkg::NUM_VEC || NV < 1) begin : g_bad_nv
      $error("vector count out of range");
    end
  endgenerate

  logic [7:0] vector_priority_regs [npic_pkg::NUM_PRIO_REG];
  logic [NV-1:0] s1, s2, s3, edge_latch, take_onehot;
  logic [1:0] lvl;
  logic [7:0] cc_rest;
  npic_pkg::npic_pwr_t pwr, next_pwr;
  logic reset_entry, halt_first;

  // OR of the four pins of each selected external line
  logic [NV-1:0] ext_raw;
  genvar g;
  generate
    for (g = 0; g < NV; g++) begin : g_or
      assign ext_raw[g] = ext_pin_sel[g] & (|ext_pins[4*g+3:4*g]); // [RULE18]
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= ext_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a pin change counts once the second and third stages agree
  logic [NV-1:0] ext_level, next_ext_level;
  assign next_ext_level = (s2 & s3) | (ext_level & (s2 | s3));
  wire [NV-1:0] ext_rise = next_ext_level & ~ext_level;

  // software priority per vector, with nonmaskable code above everything
  function automatic logic [1:0] rank(input logic [1:0] code);
    case (code)
      npic_pkg::LVL0: rank = 2'h0;
      npic_pkg::LVL1: rank = 2'h1;
      npic_pkg::LVL2: rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction // [RULE9]

  logic [1:0] vprio [NV];
  logic [NV-1:0] req, elig;
  generate
    for (g = 0; g < NV; g++) begin : g_src
      assign vprio[g] = vector_priority_regs[g/4][2*(g%4)+:2];
      assign req[g] = (periph_flag[g] & periph_enable[g]) // [RULE19]
                    | edge_latch[g]
                    | (~ext_edge_mode[g] & ext_level[g]);
      // enabled and above current level; else stays pending [RULE16]
      assign elig[g] = req[g] & (rank(vprio[g]) > rank(lvl))
                     & (~halt_first | halt_capable[g]); // [RULE22]
    end
  endgenerate
  assign pending = req; // [RULE11]

  // pick highest software rank, lowest index breaks ties
  logic [3:0] win_idx;
  logic win_any;
  logic [1:0] win_rank;
  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    win_rank = 2'h0;
    for (int i = NV - 1; i >= 0; i--) begin
      if (elig[i] && (!win_any || rank(vprio[i]) >= win_rank)) begin
        win_any = 1'b1;
        win_idx = 4'(i);
        win_rank = rank(vprio[i]);
      end
    end
  end // [RULE10]

  // wake: any request or trap from wait, only halt-capable requests or trap from halt
  wire wake_any = |req;
  wire wake_halt = |(req & halt_capable); // [RULE21]
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      npic_pkg::NPIC_RUN: begin
        if (halt_enter)
          next_pwr = npic_pkg::NPIC_HALT;
        else if (wait_enter)
          next_pwr = npic_pkg::NPIC_WAIT;
      end
      npic_pkg::NPIC_WAIT: begin
        if (wake_any || trap_req)
          next_pwr = npic_pkg::NPIC_RUN;
      end
      npic_pkg::NPIC_HALT: begin
        if (wake_halt || trap_req)
          next_pwr = npic_pkg::NPIC_RUN; // [RULE14]
      end
      default: next_pwr = npic_pkg::NPIC_RUN;
    endcase
  end
  assign cpu_run = (pwr == npic_pkg::NPIC_RUN);

  // take at boundary only, except reset entry; trap and reset outrank all maskable [RULE12]
  wire boundary = insn_boundary & cpu_run; // [RULE4] [RULE23]
  wire take_trap = boundary & trap_req & ~reset_entry; // [RULE13]
  wire take_mask = boundary & win_any & ~trap_req & ~reset_entry;
  assign service_take = reset_entry | take_trap | take_mask;
  assign stack_context = take_trap | take_mask; // [RULE5]
  assign vector_nmi = reset_entry | take_trap;
  assign take_onehot = take_mask ? (NV'(1) << win_idx) : '0;

  wire [15:0] mask_vec = npic_pkg::VEC_BASE - {11'h0, win_idx, 1'b0};
  assign vector_addr = reset_entry ? npic_pkg::VEC_RESET :
                       take_trap ? npic_pkg::VEC_TRAP : mask_vec; // [RULE3] [RULE7]
  assign vector_num = win_idx;

  wire [1:0] next_lvl_take = vector_nmi ? npic_pkg::LVL3 : vprio[win_idx];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_level <= '0;
      pwr <= npic_pkg::NPIC_RUN;
      reset_entry <= 1'b1;
      halt_first <= 1'b0;
    end else begin
      ext_level <= next_ext_level;
      pwr <= next_pwr;
      reset_entry <= 1'b0; // [RULE15]
      if (pwr == npic_pkg::NPIC_HALT && next_pwr == npic_pkg::NPIC_RUN)
        halt_first <= 1'b1;
      else if (service_take)
        halt_first <= 1'b0; // [RULE22]
    end
  end

  // edge latches: set wins over entry clear and software clear
  logic [NV-1:0] next_edge_latch;
  assign next_edge_latch = (ext_rise & ext_edge_mode)
                         | (edge_latch & ~take_onehot & ~src_clear); // [RULE17] [RULE20]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      edge_latch <= '0;
    else
      edge_latch <= next_edge_latch;
  end

  // condition code: level in bits 5 and 3
  logic [1:0] next_lvl;
  logic [7:0] next_cc_rest;
  always_comb begin
    next_lvl = lvl;
    next_cc_rest = cc_rest;
    if (service_take) begin
      next_lvl = next_lvl_take; // [RULE6] [RULE13]
    end else if (return_from_handler && boundary) begin
      next_lvl = {popped_cc[npic_pkg::CC_LVL_HIGH_POS],
                  popped_cc[npic_pkg::CC_LVL_LOW_POS]}; // [RULE8]
      next_cc_rest = popped_cc;
    end else if (cc_write) begin
      next_lvl = {cc_wdata[npic_pkg::CC_LVL_HIGH_POS],
                  cc_wdata[npic_pkg::CC_LVL_LOW_POS]};
      next_cc_rest = cc_wdata;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl <= npic_pkg::LVL3;
      cc_rest <= npic_pkg::CC_RESET;
    end else begin
      lvl <= next_lvl;
      cc_rest <= next_cc_rest;
    end
  end
  always_comb begin
    condition_code_reg = cc_rest;
    condition_code_reg[npic_pkg::CC_LVL_HIGH_POS] = lvl[1]; // [RULE2]
    condition_code_reg[npic_pkg::CC_LVL_LOW_POS] = lvl[0];
  end
  assign level_bit_high = lvl[1];
  assign level_bit_low = lvl[0];

  // priority registers: level-0 code writes keep the old field
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v);
    merge = new_v;
    for (int k = 0; k < 4; k++) begin
      if (new_v[2*k+:2] == npic_pkg::LVL0)
        merge[2*k+:2] = old_v[2*k+:2]; // [RULE25]
    end
  endfunction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < npic_pkg::NUM_PRIO_REG; r++)
        vector_priority_regs[r] <= npic_pkg::PRIO_RESET; // [RULE24]
    end else if (prio_we) begin
      vector_priority_regs[prio_addr] <=
        merge(vector_priority_regs[prio_addr], prio_wdata);
    end
  end
  assign prio_rdata = (prio_addr == 2'h3) ?
    (vector_priority_regs[3] | npic_pkg::LAST_REG_FIXED) :
    vector_priority_regs[prio_addr]; // [RULE24]
  // sixteen vector slots: reset, trap and fourteen maskable [RULE1]
endmodule
`default_nettype wire

// >>> verilog/npic_pkg.sv
// Summary of operation
// RULE1: four software nesting levels, sixteen hardware-fixed vectors.
// RULE2: current level held in condition-code bits five and three.
// RULE3: vector addresses fixed from FFE0h to FFFFh by hardware order.
// RULE4: current instruction completes before the service entry begins.
// RULE5: entry pushes program counter, index, accumulator and condition code.
// RULE6: entry loads level bits from the serviced vector's priority field.
// RULE7: after stacking, program counter loads vector address, routine fetched.
// RULE8: return pops saved registers, restoring the previous level bits.
// RULE9: level codes: 0=10, 1=01, 2=00, 3=11 (high bit, low bit).
// RULE10: highest software priority wins; ties go to fixed hardware order.
// RULE11: unserviced requests stay latched until they become highest.
// RULE12: reset and trap count as highest software priority.
// RULE13: non-maskable events ignore level; stack except reset; set level 3.
// RULE14: reset and trap both wake the processor from halt.
// RULE15: after reset the first routine runs at level 3, top hardware order.
// RULE16: maskable request served only if enabled and above current level.
// RULE17: edge external requests latch and clear on routine entry.
// RULE18: pins sharing one external line are ORed together.
// RULE19: peripheral request raised only while flag and enable both set.
// RULE20: source clear sequence resets the latch, dropping a pending request.
// RULE21: any source wakes from wait; only halt-capable ones wake from halt.
// RULE22: on halt exit a halt-capable source goes first, then the rest.
// RULE23: arbitration evaluated at every instruction boundary.
// RULE24: priority registers reset to all ones; last register upper nibble ones.
// RULE25: writing the level-0 code into a priority field is ignored.
`default_nettype none
package npic_pkg;
  localparam int NUM_VEC = 14;
  localparam int NUM_PRIO_REG = 4;
  localparam int CC_LVL_HIGH_POS = 5;
  localparam int CC_LVL_LOW_POS = 3;
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] LAST_REG_FIXED = 8'hF0;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_BASE = 16'hFFFA;
  localparam logic [15:0] VEC_LOW = 16'hFFE0;
  localparam logic [7:0] CC_RESET = 8'hEA;
  typedef enum logic [1:0] {
    NPIC_RUN = 2'h0,
    NPIC_WAIT = 2'h1,
    NPIC_HALT = 2'h2
  } npic_pwr_t;
endpackage
`default_nettype wire

// >>> bench/npic_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module npic_ctrl_asserts (
  // watched controller ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic insn_boundary,
  input wire logic trap_req,
  input wire logic return_from_handler,
  input wire logic [7:0] popped_cc,
  input wire logic service_take,
  input wire logic stack_context,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] vector_num,
  input wire logic vector_nmi,
  input wire logic [7:0] condition_code_reg,
  input wire logic level_bit_high,
  input wire logic level_bit_low,
  input wire logic cpu_run
);
  wire logic [1:0] lv = {level_bit_high, level_bit_low};
  wire logic [1:0] pl = {popped_cc[5], popped_cc[3]};
  wire logic rv = vector_addr == 16'hFFFE;
  function automatic logic [1:0] rk(logic [1:0] c);
    return c == 2'h3 ? 2'h3 : 2'h2 - c;
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_cc;
    lv == {condition_code_reg[5], condition_code_reg[3]};
  endproperty
  a_cc: assert property (p_cc) else $error("level bits off");
  property p_vec;
    service_take && !vector_nmi |-> vector_num < 4'hE &&
      vector_addr == 16'hFFFA - {11'h0, vector_num, 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_bnd;
    service_take && !rv |-> insn_boundary && cpu_run;
  endproperty
  a_bnd: assert property (p_bnd) else $error("take off boundary");
  property p_stk;
    service_take |-> stack_context == !rv;
  endproperty
  a_stk: assert property (p_stk) else $error("bad stacking");
  property p_nmi;
    service_take && vector_nmi |=> lv == 2'h3;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi level");
  property p_ret;
    return_from_handler && insn_boundary && cpu_run && !service_take
      |=> lv == $past(pl);
  endproperty
  a_ret: assert property (p_ret) else $error("return level");
  property p_trp;
    insn_boundary && cpu_run && trap_req |-> service_take && vector_nmi;
  endproperty
  a_trp: assert property (p_trp) else $error("trap not taken");
  property p_msk;
    service_take && !vector_nmi |=> rk(lv) > rk($past(lv));
  endproperty
  a_msk: assert property (p_msk) else $error("not above level");
endmodule
bind npic_ctrl npic_ctrl_asserts i_npic_ctrl_asserts (.*);
`default_nettype wire

// >>> bench/npic_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module npic_cpu_model (
  // clock, reset, bench control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  input wire logic ret_go,
  // controller side
  input wire logic service_take,
  input wire logic stack_context,
  input wire logic [7:0] condition_code_reg,
  output logic insn_boundary,
  output logic return_from_handler,
  output logic [7:0] popped_cc
);
  logic [7:0] stk [$];
  logic [7:0] top = 8'h00;
  logic [1:0] cnt;
  logic go_q = 1'b0;
  logic slow_q = 1'b0;
  int depth = 0;
  assign return_from_handler = ret_go & insn_boundary & (depth != 0);
  // idle value is inverted so a stale read cannot match
  assign popped_cc = return_from_handler ? top : ~top;
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      insn_boundary <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      insn_boundary <= go_q & (!slow_q | cnt == 2'h0);
    end
  end
  always @(posedge core_clk) begin
    // bench controls are captured here so the falling-edge update cannot race
    go_q <= go;
    slow_q <= slow;
    if (!rst_n) stk.delete();
    // a return that meets an entry is dropped by the controller
    if (return_from_handler && !service_take) void'(stk.pop_back());
    if (service_take && stack_context) stk.push_back(condition_code_reg);
    depth <= stk.size();
    top <= stk.size() != 0 ? stk[$] : 8'h00;
  end
endmodule
`default_nettype wire

// >>> bench/nested_priority_interrupt_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module nested_priority_interrupt_ctrl_test;
  logic core_clk = 0, rst_n = 0, go = 0, slow = 0, ret_go = 0, on = 0;
  logic trap_req = 0, cc_write = 0, wait_enter = 0, halt_enter = 0;
  logic prio_we = 0, chk = 1, hf = 0, t;
  logic [1:0] prio_addr = 0, lv = 2'h3;
  logic [1:0] pr [14];
  logic [1:0] q [$];
  logic [7:0] cc_wdata = 0, prio_wdata = 0, popped_cc;
  logic [55:0] ext_pins = 0;
  logic [13:0] ext_pin_sel = 0, ext_edge_mode = 0, periph_flag = 0, el = 0;
  logic [13:0] periph_enable = 0, src_clear = 0, halt_capable = 0, rq;
  logic [13:0] pending;
  logic [31:0] r = 32'hF5DD4332;
  int n_errors = 0, samples_checked = 0, cyc = 0, b;
  logic insn_boundary, return_from_handler, service_take, stack_context;
  logic vector_nmi, level_bit_high, level_bit_low, cpu_run;
  logic [7:0] condition_code_reg, prio_rdata;
  logic [15:0] vector_addr;
  logic [3:0] vector_num;
  npic_ctrl i_npic_ctrl (.*);
  npic_cpu_model i_npic_cpu_model (.*);
  always #4 core_clk = ~core_clk;
  function automatic logic [1:0] rk(logic [1:0] c);
    return c == 2'h3 ? 2'h3 : 2'h2 - c;
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic pw(logic [1:0] a, logic [7:0] d);
    @(negedge core_clk);
    {prio_we, prio_addr, prio_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    prio_we = 0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e);
    @(negedge core_clk);
    prio_addr = a;
    #1 cmp("prio_rdata", e, prio_rdata);
  endtask
  task automatic ccw(logic [1:0] l);
    @(negedge core_clk);
    {cc_write, cc_wdata} = {1'b1, 2'h3, l[1], 1'b0, l[0], 3'h2};
    @(negedge core_clk);
    cc_write = 0;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      results();
    end
    if (on) begin
      rq = periph_flag & periph_enable | el;
      if (chk) cmp("pending", rq, pending);
      cmp("level", lv, {level_bit_high, level_bit_low});
      b = -1;
      for (int n = 0; n < 14; n++)
        if (rq[n] && (!hf || halt_capable[n]) && rk(pr[n]) > rk(lv) &&
            (b < 0 || rk(pr[n]) > rk(pr[b]))) b = n;
      t = insn_boundary && (trap_req || b >= 0);
      cmp("take", t, service_take);
      if (t) begin
        cmp("vector", trap_req ? 16'hFFFC : 16'hFFFA - 16'(2 * b),
            vector_addr);
        cmp("stack", 1, stack_context);
        cmp("nmi", trap_req, vector_nmi);
        if (!trap_req) cmp("vector_num", 16'(b), vector_num);
        q.push_back(lv);
        lv = trap_req ? 2'h3 : pr[b];
        hf = 0;
        if (!trap_req && b == 2) el[2] = 0;
      end else if (return_from_handler) lv = q.pop_back();
      else if (cc_write) lv = {cc_wdata[5], cc_wdata[3]};
    end
    if (prio_we)
      for (int k = 0; k < 4; k++)
        if (4 * prio_addr + k < 14 && prio_wdata[2*k+:2] != 2'h2)
          pr[4*prio_addr+k] = prio_wdata[2*k+:2];
  end
  initial begin
    for (int i = 0; i < 14; i++) pr[i] = 2'h3;
    repeat (10) @(negedge core_clk);
    rst_n = 1;
    #1 cmp("reset_take", 16'hFFFE, service_take ? vector_addr : 16'h0);
    cmp("reset_stack", 0, stack_context);
    @(negedge core_clk) on = 1;
    cmp("cc_reset", 16'hEA, condition_code_reg);
    for (int a = 0; a < 4; a++) rd(2'(a), 8'hFF);
    pw(3, 8'h00);
    rd(3, 8'hF0);
    pw(0, 8'hCF);
    pw(0, 8'h64);
    rd(0, 8'h44);
    ccw(2'h2);
    chk = 0;
    {ext_pin_sel[2], ext_edge_mode[2], ext_pins[9]} = 3'h7;
    repeat (2) @(negedge core_clk);
    ext_pins[9] = 0;
    repeat (6) @(negedge core_clk);
    cmp("edge_latch", 1, pending[2]);
    src_clear[2] = 1;
    @(negedge core_clk) src_clear[2] = 0;
    @(negedge core_clk) cmp("clear_seq", 0, pending[2]);
    {ext_edge_mode[2], ext_pins[10]} = 2'h1;
    repeat (4) @(negedge core_clk);
    cmp("level_sense", 1, pending[2]);
    ext_pins[10] = 0;
    repeat (4) @(negedge core_clk);
    cmp("level_drop", 0, pending[2]);
    ext_edge_mode[2] = 1;
    ext_pins[11] = 1;
    repeat (2) @(negedge core_clk);
    ext_pins[11] = 0;
    repeat (6) @(negedge core_clk);
    cmp("pin_or", 1, pending[2]);
    {el[2], chk, go} = 3'h7;
    repeat (4) @(negedge core_clk);
    {go, ext_pin_sel, ext_edge_mode} = 0;
    pw(0, 8'hFF);
    pw(1, 8'h55);
    ccw(2'h2);
    {periph_enable, halt_capable} = {14'h3FFF, 14'h0010};
    halt_enter = 1;
    @(negedge core_clk) {halt_enter, periph_flag[1]} = 2'h1;
    repeat (5) @(negedge core_clk);
    cmp("halt_hold", 0, cpu_run);
    periph_flag[4] = 1;
    for (int i = 0; i < 8 && cpu_run !== 1; i++) @(negedge core_clk);
    cmp("halt_wake", 1, cpu_run);
    {hf, go} = 2'h3;
    repeat (6) @(negedge core_clk);
    {go, periph_flag} = 0;
    ccw(2'h2);
    wait_enter = 1;
    @(negedge core_clk) {wait_enter, periph_flag[8]} = 2'h1;
    cmp("wait_hold", 0, cpu_run);
    for (int i = 0; i < 8 && cpu_run !== 1; i++) @(negedge core_clk);
    cmp("wait_wake", 1, cpu_run);
    go = 1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      r = lfsr(r);
      {ret_go, slow} = {r[0] & r[1], r[2] & r[3]};
      periph_flag = ret_go ? 14'h0 : r[17:4];
      {periph_enable, halt_capable} = {r[31:18], r[27:14]};
      ext_pins = {r, r[23:0]};
      trap_req = !ret_go && r[7:5] == 3'h7;
      cc_write = !ret_go && r[10:8] == 3'h0;
      {cc_wdata, prio_wdata, prio_addr} = {r[31:24], r[23:16], r[14:13]};
      prio_we = r[12:11] == 2'h0;
    end
    results();
  end
endmodule
`default_nettype wire
